/* design/capture_params.svh */
// Register offsets, field positions and reset values of the capture channel
`ifndef CAPTURE_PARAMS_SVH
`define CAPTURE_PARAMS_SVH
`define CAP_ADDR_W 4
`define CAP_OFS_CTRL 4'h0
`define CAP_OFS_STATUS 4'h1
`define CAP_OFS_MASK 4'h2
`define CAP_OFS_VALUE 4'h3
`define CAP_OFS_FLAGS 4'h4
`define CAP_CTRL_CAPEN 0
`define CAP_CTRL_EVIEN 1
`define CAP_CTRL_DIR 2
`define CAP_CTRL_EVOEN 3
`define CAP_CTRL_DMAEN 4
`define CAP_CTRL_RESET 8'h00
`define CAP_ST_FLAG 0
`define CAP_ST_OVF 1
`define CAP_MASK_RESET 2'h0
`define CAP_CNT_W 16
`endif

/* design/capture_pkg.sv */
// Types shared by the capture channel files
package capture_pkg;
  typedef logic [15:0] count_t;
  typedef logic [3:0] addr_t;
  typedef enum logic [1:0] {
    ST_EMPTY = 2'b00,
    ST_FULL = 2'b01,
    ST_BOTH = 2'b11
  } stage_t;
endpackage

/* design/capture_counter.sv */
// Free running up/down timebase counter
`timescale 1ns/10ps
module capture_counter
  import capture_pkg::*;
(
  // Clock and control
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic down,
  // Count value
  output capture_pkg::count_t count
);
  count_t count_reg;
  count_t count_next;

  assign count_next = down ? count_t'(count_reg - 16'h0001) : count_t'(count_reg + 16'h0001);
  assign count = count_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_reg <= 16'h0000;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end
endmodule

/* design/timer_input_capture_channel.sv */
// Input capture channel with two-stage store, flags and interrupt
`timescale 1ns/10ps
`include "capture_params.svh"
// Behaviour
// R1: In capture mode each routed event timestamps the running counter value.
// R2: Empty or just-read visible register takes pending hidden buffer content.
// R3: That transfer sets the capture flag and raises optional irq, event, DMA.
// R4: Hidden buffer never readable; values come only from the visible register.
// R5: Up-counting cannot capture zero; down-counting captures the full range.
// R6: Event while capture flag still set is dropped and sets overflow flag.
// R7: Events reach the channel only while event input enable is one.
// R8: Reading the visible capture register clears the capture flag.
module timer_input_capture_channel
  import capture_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Event from routing system, same clock
  input wire logic capture_event,
  // Register port
  input wire capture_pkg::addr_t reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Requests
  output logic irq,
  output logic capture_event_out,
  output logic dma_req
);
  import capture_pkg::*;

  logic [7:0] ctrl_reg;
  logic [1:0] mask_reg;
  logic capture_flag;
  logic capture_overflow_flag;
  count_t capture_value_reg;
  count_t capture_buffer_stage;
  stage_t stage_reg;
  stage_t stage_next;
  logic [15:0] rdata_reg;
  logic irq_reg;
  logic evout_reg;
  logic dma_reg;
  count_t count;

  capture_counter u_counter (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .down(ctrl_reg[`CAP_CTRL_DIR]),
    .count(count)
  );

  function automatic logic hit(input addr_t a, input addr_t ofs, input logic stb);
    hit = stb && (a == ofs);
  endfunction

  wire capture_enable = ctrl_reg[`CAP_CTRL_CAPEN];
  wire event_input_enable = ctrl_reg[`CAP_CTRL_EVIEN];
  wire count_direction = ctrl_reg[`CAP_CTRL_DIR];
  wire ev_in = capture_event && event_input_enable && capture_enable; // R7 R1
  // Zero while counting up never appears as a sample
  wire zero_blocked = !count_direction && (count == 16'h0000); // R5

  wire wr_ctrl = hit(reg_addr, `CAP_OFS_CTRL, reg_wr);
  wire wr_status = hit(reg_addr, `CAP_OFS_STATUS, reg_wr);
  wire wr_mask = hit(reg_addr, `CAP_OFS_MASK, reg_wr);
  wire rd_value = hit(reg_addr, `CAP_OFS_VALUE, reg_rd);

  wire has_buf = (stage_reg == ST_BOTH);
  wire has_vis = (stage_reg != ST_EMPTY);

  // Overflow check guards the whole store against new events
  wire overrun = ev_in && capture_flag; // R6
  wire store = ev_in && !capture_flag && !zero_blocked; // R1
  // Visible empty or being read: move buffer forward
  wire vis_free = !has_vis || rd_value; // R2
  wire xfer_buf = vis_free && has_buf; // R2
  wire direct = vis_free && !has_buf && store;
  wire load_vis = xfer_buf || direct; // R3
  // Full store: a new sample is dropped, never overwrites the hidden stage
  wire buf_full = has_buf && !rd_value; // R6
  wire buf_wr = store && !direct && !buf_full;
  wire ovf_set = overrun || (store && buf_full);

  wire flag_clr = rd_value || (wr_status && reg_wdata[`CAP_ST_FLAG]); // R8
  wire ovf_clr = wr_status && reg_wdata[`CAP_ST_OVF];
  wire evout_set = load_vis && ctrl_reg[`CAP_CTRL_EVOEN]; // R3
  wire dma_set = load_vis && ctrl_reg[`CAP_CTRL_DMAEN]; // R3
  wire [1:0] status_bits = {capture_overflow_flag, capture_flag};
  wire [1:0] irq_bits = status_bits & mask_reg;

  always_comb begin
    stage_next = stage_reg;
    case (stage_reg)
      ST_EMPTY: begin
        if (store) begin
          stage_next = ST_FULL;
        end
      end
      ST_FULL: begin
        if (rd_value && !store) begin
          stage_next = ST_EMPTY;
        end else if (!rd_value && store) begin
          stage_next = ST_BOTH;
        end
      end
      ST_BOTH: begin
        if (rd_value && !store) begin
          stage_next = ST_FULL;
        end
      end
      default: begin
        stage_next = ST_EMPTY;
      end
    endcase
  end

  // Hidden stage is never on the read mux
  wire [15:0] rdata_next =
    (reg_addr == `CAP_OFS_CTRL) ? {8'h00, ctrl_reg} :
    (reg_addr == `CAP_OFS_STATUS) ? {14'h0000, status_bits} :
    (reg_addr == `CAP_OFS_MASK) ? {14'h0000, mask_reg} :
    (reg_addr == `CAP_OFS_VALUE) ? capture_value_reg : 16'h0000; // R4

  // Software settings
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_reg <= `CAP_CTRL_RESET;
      mask_reg <= `CAP_MASK_RESET;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata[7:0];
      end
      if (wr_mask) begin
        mask_reg <= reg_wdata[1:0];
      end
    end
  end

  // Two-stage store
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stage_reg <= ST_EMPTY;
      capture_value_reg <= 16'h0000;
      capture_buffer_stage <= 16'h0000;
    end else if (ce) begin
      stage_reg <= stage_next;
      if (buf_wr) begin
        capture_buffer_stage <= count; // R1
      end
      if (xfer_buf) begin
        capture_value_reg <= capture_buffer_stage; // R2
      end else if (direct) begin
        capture_value_reg <= count; // R1
      end
    end
  end

  // Read data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_reg <= 16'h0000;
    end else if (ce) begin
      rdata_reg <= reg_rd ? rdata_next : 16'h0000;
    end
  end

  // Flags: set beats clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      capture_flag <= 1'b0;
    end else if (ce) begin
      if (load_vis) begin
        capture_flag <= 1'b1; // R3
      end else if (flag_clr) begin
        capture_flag <= 1'b0; // R8
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      capture_overflow_flag <= 1'b0;
    end else if (ce) begin
      if (ovf_set) begin
        capture_overflow_flag <= 1'b1; // R6
      end else if (ovf_clr) begin
        capture_overflow_flag <= 1'b0;
      end
    end
  end

  // Level interrupt lags the flags by one cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_reg <= 1'b0;
      evout_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= |irq_bits;
      evout_reg <= evout_set; // R3
    end
  end

  // Request held until software reads the value
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dma_reg <= 1'b0;
    end else if (ce) begin
      if (dma_set) begin
        dma_reg <= 1'b1; // R3
      end else if (rd_value) begin
        dma_reg <= 1'b0;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;
  assign capture_event_out = evout_reg;
  assign dma_req = dma_reg;
endmodule

/* tb/event_route_model.sv */
// Event routing model feeding the capture channel
`timescale 1ns/10ps
module event_route_model (
  // Clock and request
  input wire logic clk_sys,
  input wire logic fire,
  // Routed event
  output logic capture_event
);
  // Registered: a routed event leaves on a clock edge as one pulse
  always_ff @(posedge clk_sys) capture_event <= fire;
endmodule

/* tb/capture_chk_sva.sv */
// Port checker of the capture channel
`timescale 1ns/10ps
module capture_chk_sva (
  // Clock and inputs
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic capture_event,
  input wire capture_pkg::addr_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // Outputs
  input wire logic [15:0] reg_rdata,
  input wire logic irq,
  input wire logic capture_event_out,
  input wire logic dma_req
);
  logic [2:0] hist;
  // Recent activity; outputs may only move shortly after some
  always_ff @(posedge clk_sys) hist <= srst ? 3'h0 : {hist[1:0], capture_event | reg_wr | reg_rd};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0) else $error("data without read");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
  AST_DMA_HOLD: assert property (dma_req && !reg_rd |=> dma_req) else $error("dma dropped");
  AST_DMA_FALL: assert property ($fell(dma_req) |-> $past(reg_rd)) else $error("dma fell");
  AST_DMA_RISE: assert property ($rose(dma_req) |-> hist != 3'h0) else $error("dma rose");
  AST_IRQ_STILL: assert property (hist == 3'h0 |-> $stable(irq)) else $error("irq moved");
  AST_EVO_CAUSE: assert property (capture_event_out |-> hist != 3'h0) else $error("evo");
  AST_DMA_STILL: assert property (hist == 3'h0 |-> $stable(dma_req)) else $error("dma moved");
  cover property (capture_event_out);
  cover property ($fell(irq));
  cover property ($fell(dma_req));
endmodule
bind timer_input_capture_channel capture_chk_sva u_chk (.clk_sys, .srst, .capture_event,
  .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .irq, .capture_event_out, .dma_req);

/* tb/tb_top.sv */
// Self-checking bench of the capture channel
`timescale 1ns/10ps
`include "capture_params.svh"
module tb_top;
  import capture_pkg::*;
  logic clk_sys = 1'b0, srst = 1'b1, ce = 1'b1, fire = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic ev, irq, evo, dma_req;
  addr_t reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, v1, v2, s;
  logic [31:0] lf = 32'h1674;
  int fail_count = 0, num_checks = 0, cyc = 0, e1, e2;
  always #50 clk_sys = ~clk_sys;
  event_route_model u_evt (.clk_sys(clk_sys), .fire(fire), .capture_event(ev));
  timer_input_capture_channel u_dut (.clk_sys(clk_sys), .srst(srst), .ce(ce),
    .capture_event(ev), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .capture_event_out(evo),
    .dma_req(dma_req));
  function automatic logic [15:0] span(input logic dn, input logic [15:0] a, b);
    return dn ? a - b : b - a;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic w(input addr_t a, input logic [15:0] dat);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic r(input addr_t a, output logic [15:0] dat);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 dat = reg_rdata;
  endtask
  task automatic f(output int t);
    @(posedge clk_sys);
    fire <= 1'b1;
    t = cyc;
    @(posedge clk_sys);
    fire <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Ceiling well above the roughly 160 cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    w(`CAP_OFS_MASK, 16'h1);
    // Up first: a later up run could wrap through the uncapturable zero
    for (int i = 0; i < 4; i++) begin
      w(`CAP_OFS_CTRL, {11'h0, 2'b11, i[1], 2'b11});
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      f(e1);
      @(posedge clk_sys);
      #1 chk({15'h0, evo}, 16'h1);
      settle();
      chk({14'h0, irq, dma_req}, 16'h3);
      r(`CAP_OFS_VALUE, v1);
      r(`CAP_OFS_STATUS, s);
      chk(s, 16'h0);
      repeat (2 + lf[3:0]) @(posedge clk_sys);
      f(e2);
      settle();
      r(`CAP_OFS_VALUE, v2);
      chk(span(i[1], v1, v2), 16'(e2 - e1));
    end
    f(e1);
    f(e2);
    settle();
    r(`CAP_OFS_STATUS, s);
    chk(s, 16'h3);
    r(`CAP_OFS_VALUE, v1);
    w(`CAP_OFS_STATUS, 16'h3);
    r(`CAP_OFS_STATUS, s);
    chk({s[15:1], irq}, 16'h0);
    w(`CAP_OFS_CTRL, 16'h001D);
    f(e1);
    settle();
    r(`CAP_OFS_STATUS, s);
    chk(s, 16'h0);
    r(4'hF, s);
    chk(s, 16'h0);
    // A capture after a flag clear waits in the hidden stage
    w(`CAP_OFS_CTRL, 16'h0007);
    f(e1);
    settle();
    w(`CAP_OFS_STATUS, 16'h1);
    f(e2);
    settle();
    r(`CAP_OFS_VALUE, v1);
    r(`CAP_OFS_STATUS, s);
    chk(s, 16'h1);
    r(`CAP_OFS_VALUE, v2);
    chk(span(1'b1, v1, v2), 16'(e2 - e1));
    // Frozen clock enable: the event in that cycle is not taken
    @(posedge clk_sys);
    ce <= 1'b0;
    f(e1);
    @(posedge clk_sys);
    ce <= 1'b1;
    settle();
    r(`CAP_OFS_STATUS, s);
    chk(s, 16'h0);
    summarize();
  end
endmodule
